// File: common/psec_pkg.sv
/*
  Types shared by the PHY status and error counter bank.
  Assumes all line indications come from logic on the same clock.
*/
package psec_pkg;
  // Line and negotiation state presented by the PHY core
  typedef struct packed {
    logic lp_rem_fault;
    logic jabber;
    logic an_enable;
    logic an_complete;
    logic loopback;
    logic link_ok;
    logic an_full_dup;
    logic an_low_speed;
    logic frc_full_dup;
    logic frc_low_speed;
  } psec_phy_s;
  // Receive path events
  typedef struct packed {
    logic carrier;
    logic invalid_sym;
    logic collision;
    logic false_carrier;
  } psec_rx_s;
  // Quick status layout, bit 7 down to bit 0
  typedef struct packed {
    logic rsvd;
    logic rem_fault;
    logic jabber;
    logic an_complete;
    logic loopback;
    logic full_dup;
    logic low_speed_flag;
    logic link;
  } psec_quick_s;
  // Bus access phase
  typedef enum logic {
    PSEC_BUS_IDLE = 1'b0,
    PSEC_BUS_ANSWER = 1'b1
  } psec_bus_e;
endpackage

// File: common/psec_regs_regs.svh
/*
  Register offsets, field positions and reset values of the PHY status
  and error counter bank. Assumes a 32-bit bus with one register per
  word; the byte address of a register is four times its index.
*/
`ifndef PSEC_REGS_REGS_SVH
`define PSEC_REGS_REGS_SVH
// Register indices (byte address = index * 4)
`define PSEC_IDX_BASIC 6'h01
`define PSEC_IDX_QUICK 6'h10
`define PSEC_IDX_FCAR 6'h14
`define PSEC_IDX_RXER 6'h15
`define PSEC_IDX_ISTAT 6'h20
`define PSEC_IDX_IMASK 6'h21
// Basic status field positions
`define PSEC_BAS_JAB 1
`define PSEC_BAS_LINK 2
`define PSEC_BAS_RF 4
`define PSEC_BAS_ANC 5
// Interrupt status field positions and width
`define PSEC_IRQ_FCAR 0
`define PSEC_IRQ_RXER 1
`define PSEC_IRQ_RF 2
`define PSEC_IRQ_LDN 3
`define PSEC_IRQ_W 4
// Reset values
`define PSEC_CNT_RST 8'h00
`define PSEC_ISTAT_RST 4'h0
`define PSEC_IMASK_RST 4'h0
`define PSEC_RDATA_RST 32'h00000000
`endif

// File: hdl/psec_rx_err_qual.sv
/*
  Qualifies receive symbol errors: one pulse per carrier event that held
  an invalid symbol and no collision. Assumes same-clock inputs.
*/
`timescale 1ns/100ps
module psec_rx_err_qual (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Receive line state
  input wire logic carrier,
  input wire logic invalid_sym,
  input wire logic collision,
  // Count request, one cycle after carrier ends
  output logic count_q
);
  logic carrier_q;
  logic err_seen_q;
  logic coll_seen_q;
  logic start;
  logic fall;

  assign start = carrier && !carrier_q;
  assign fall = !carrier && carrier_q;

  // Track each carrier event; verdict only at its end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      carrier_q <= 1'b0;
      err_seen_q <= 1'b0;
      coll_seen_q <= 1'b0;
      count_q <= 1'b0;
    end else begin
      carrier_q <= carrier;
      if (start) begin
        err_seen_q <= invalid_sym;
        coll_seen_q <= collision;
      end else if (carrier) begin
        err_seen_q <= err_seen_q | invalid_sym;
        coll_seen_q <= coll_seen_q | collision;
      end
      // once per event, none with collision
      count_q <= fall && err_seen_q && !coll_seen_q;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_RXER_NO_COLL:
  assert property (fall && coll_seen_q |=> !count_q)
    else $error("error counted despite collision");
  AST_RXER_ONCE:
  assert property (count_q |=> !count_q)
    else $error("more than one count per carrier");
endmodule

// File: hdl/psec_sat_counter.sv
/*
  Saturating clear-on-read event counter.
  Assumes clear and write strobes are one-cycle pulses on clk.
*/
`timescale 1ns/100ps
module psec_sat_counter #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic inc,
  input wire logic clr,
  input wire logic wr_en,
  input wire logic [W-1:0] wr_data,
  // Count
  output logic [W-1:0] count_q
);
  logic [W-1:0] count_d;
  logic [W-1:0] base;

  // Clear or write first, then the event adds on top so none is lost
  always_comb begin
    base = clr ? '0 : (wr_en ? wr_data : count_q);
    count_d = base;
    if (inc && (base != {W{1'b1}})) begin
      count_d = base + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_CNT_STICKS:
  assert property (inc && !clr && !wr_en && count_q == {W{1'b1}}
    |=> count_q == {W{1'b1}}) else $error("counter wrapped");
  AST_CNT_CLR:
  assert property (clr && !inc |=> count_q == '0)
    else $error("read did not clear counter");
  AST_CNT_KEEP_EVENT:
  assert property (clr && inc |=> count_q == 1)
    else $error("event lost on clearing read");
endmodule

// File: hdl/psec_top.sv
/*
  PHY quick status and receive error counter bank, Avalon-MM slave.
  Assumes line and negotiation indications arrive on clk from the PHY
  core, and a bus master that holds each request until waitrequest low.
*/
// Our own choice: the Avalon-MM slave port.
// Behaviour
// - Remote fault bit 6 sets on fault, clears on basic status read or reset.
// - Remote fault counts only when signalled by partner through negotiation.
// - Bit 5 copies basic jabber; quick status read leaves it.
// - Bit 4 is one once negotiation completed, else zero.
// - Bit 3 is one while loopback is enabled.
// - Bit 2 shows duplex, negotiated or forced, one is full.
// - Duplex and speed valid only with link and negotiation done or off.
// - Bit 0 is one while a valid link exists.
// - Quick link bit mirrors basic link bit; quick read leaves it.
// - Bit 7 and counter upper bytes read zero, writes ignored.
// - False carrier counter at 0x14 counts each false carrier event.
// - False carrier counter sticks at all ones until cleared.
// - Both counters reset to zero, are writable, clear on read.
// - Error counter at 0x15 counts carriers with invalid symbols, once each.
// - No error count for a carrier event with collision.
// - Error counter sticks at maximum until a read clears it.
`timescale 1ns/100ps
`include "psec_regs_regs.svh"
module psec_top
  import psec_pkg::*;
#(
  parameter int CNT_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // PHY core state and receive events
  input wire psec_phy_s phy_i,
  input wire psec_rx_s rx_i,
  // Interrupt
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////
  // Declarations
  psec_bus_e state_q;
  logic [5:0] idx;
  logic fire;
  logic rd_fire;
  logic wr_fire;
  logic basic_rd;
  logic quick_rd;
  logic [31:0] rdata_d;
  psec_quick_s quick_q;
  logic rf_q;
  logic jab_lat_q;
  logic link_lat_q;
  logic link_ok_q;
  logic rf_set;
  logic stat_valid;
  logic [CNT_W-1:0] fcar_cnt;
  logic [CNT_W-1:0] rxer_cnt;
  logic rxer_evt;
  logic [`PSEC_IRQ_W-1:0] istat_q;
  logic [`PSEC_IRQ_W-1:0] imask_q;
  logic [`PSEC_IRQ_W-1:0] ev;
  logic [`PSEC_IRQ_W-1:0] w1c;
  logic [31:0] readdata_q;
  logic waitreq_q;
  logic irq_q;

  // Register index match, used for every read and write decode
  function automatic logic hit(input logic [5:0] a, input logic [5:0] b);
    return a == b;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Bus handshake
  // Byte address bits 1:0 are ignored; registers sit on whole words
  assign idx = avs_address[7:2];
  assign fire = (state_q == PSEC_BUS_IDLE) && (avs_read || avs_write);
  assign rd_fire = fire && avs_read;
  assign wr_fire = fire && avs_write;
  assign basic_rd = rd_fire && hit(idx, `PSEC_IDX_BASIC);
  assign quick_rd = rd_fire && hit(idx, `PSEC_IDX_QUICK);

  // Access acts in the idle cycle, answer stands one cycle after
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= PSEC_BUS_IDLE;
      waitreq_q <= 1'b1;
    end else begin
      unique case (state_q)
        PSEC_BUS_IDLE: begin
          if (fire) begin
            state_q <= PSEC_BUS_ANSWER;
            waitreq_q <= 1'b0;
          end
        end
        PSEC_BUS_ANSWER: begin
          state_q <= PSEC_BUS_IDLE;
          waitreq_q <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Latched status bits
  // fault only via negotiation
  assign rf_set = phy_i.lp_rem_fault && phy_i.an_enable;

  // remote fault sticky, set beats clearing read
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rf_q <= 1'b0;
    end else if (rf_set) begin
      rf_q <= 1'b1;
    end else if (basic_rd) begin
      rf_q <= 1'b0;
    end
  end

  // jabber latch cleared only by basic read
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      jab_lat_q <= 1'b0;
    end else if (phy_i.jabber) begin
      jab_lat_q <= 1'b1;
    end else if (basic_rd) begin
      jab_lat_q <= 1'b0;
    end
  end

  // link latch low, reloaded by basic read or when link returns
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      link_lat_q <= 1'b0;
      link_ok_q <= 1'b0;
    end else begin
      link_ok_q <= phy_i.link_ok;
      if (!phy_i.link_ok) begin
        link_lat_q <= 1'b0;
      end else if (basic_rd || !link_ok_q) begin
        link_lat_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Quick status word
  // duplex and speed only meaningful with a settled link
  assign stat_valid = phy_i.link_ok &&
                      (phy_i.an_enable ? phy_i.an_complete : 1'b1);

  // Rebuilt every cycle; reading it has no side effect
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      quick_q <= '0;
    end else begin
      quick_q.rsvd <= 1'b0;
      quick_q.rem_fault <= rf_q;
      quick_q.jabber <= jab_lat_q;
      quick_q.an_complete <= phy_i.an_complete;
      quick_q.loopback <= phy_i.loopback;
      quick_q.full_dup <= stat_valid &&
        (phy_i.an_enable ? phy_i.an_full_dup : phy_i.frc_full_dup);
      quick_q.low_speed_flag <= stat_valid &&
        (phy_i.an_enable ? phy_i.an_low_speed : phy_i.frc_low_speed);
      quick_q.link <= link_lat_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Event counters
  // false carrier count
  psec_sat_counter #(
    .W(CNT_W)
  ) u_fcar (
    .clk(clk),
    .rst_n(rst_n),
    .inc(rx_i.false_carrier),
    .clr(rd_fire && hit(idx, `PSEC_IDX_FCAR)),
    .wr_en(wr_fire && hit(idx, `PSEC_IDX_FCAR) && avs_byteenable[0]),
    .wr_data(avs_writedata[CNT_W-1:0]),
    .count_q(fcar_cnt)
  );

  psec_rx_err_qual u_qual (
    .clk(clk),
    .rst_n(rst_n),
    .carrier(rx_i.carrier),
    .invalid_sym(rx_i.invalid_sym && rx_i.carrier),
    .collision(rx_i.collision),
    .count_q(rxer_evt)
  );

  psec_sat_counter #(
    .W(CNT_W)
  ) u_rxer (
    .clk(clk),
    .rst_n(rst_n),
    .inc(rxer_evt),
    .clr(rd_fire && hit(idx, `PSEC_IDX_RXER)),
    .wr_en(wr_fire && hit(idx, `PSEC_IDX_RXER) && avs_byteenable[0]),
    .wr_data(avs_writedata[CNT_W-1:0]),
    .count_q(rxer_cnt)
  );

  ////////////////////////////////////////////////////////////////////////
  // Interrupts
  // Link down is taken from the live link, not the latch
  always_comb begin
    ev = '0;
    ev[`PSEC_IRQ_FCAR] = rx_i.false_carrier;
    ev[`PSEC_IRQ_RXER] = rxer_evt;
    ev[`PSEC_IRQ_RF] = rf_set && !rf_q;
    ev[`PSEC_IRQ_LDN] = link_ok_q && !phy_i.link_ok;
    w1c = '0;
    if (wr_fire && hit(idx, `PSEC_IDX_ISTAT) && avs_byteenable[0]) begin
      w1c = avs_writedata[`PSEC_IRQ_W-1:0];
    end
  end

  // Sticky status, a new event wins over a write-one clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      istat_q <= `PSEC_ISTAT_RST;
    end else begin
      istat_q <= (istat_q & ~w1c) | ev;
    end
  end

  // Mask register, one enables the bit onto irq
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      imask_q <= `PSEC_IMASK_RST;
    end else if (wr_fire && hit(idx, `PSEC_IDX_IMASK) &&
                 avs_byteenable[0]) begin
      imask_q <= avs_writedata[`PSEC_IRQ_W-1:0];
    end
  end

  // Level output, one cycle behind status
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(istat_q & imask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data
  // upper bits zero, unmapped reads zero
  always_comb begin
    rdata_d = '0;
    if (hit(idx, `PSEC_IDX_BASIC)) begin
      rdata_d[`PSEC_BAS_JAB] = jab_lat_q;
      rdata_d[`PSEC_BAS_LINK] = link_lat_q;
      rdata_d[`PSEC_BAS_RF] = rf_q;
      rdata_d[`PSEC_BAS_ANC] = phy_i.an_complete;
    end else if (hit(idx, `PSEC_IDX_QUICK)) begin
      rdata_d[7:0] = quick_q;
    end else if (hit(idx, `PSEC_IDX_FCAR)) begin
      rdata_d[CNT_W-1:0] = fcar_cnt;
    end else if (hit(idx, `PSEC_IDX_RXER)) begin
      rdata_d[CNT_W-1:0] = rxer_cnt;
    end else if (hit(idx, `PSEC_IDX_ISTAT)) begin
      rdata_d[`PSEC_IRQ_W-1:0] = istat_q;
    end else if (hit(idx, `PSEC_IDX_IMASK)) begin
      rdata_d[`PSEC_IRQ_W-1:0] = imask_q;
    end
  end

  // sampled at the clearing edge, so pre-clear value
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      readdata_q <= `PSEC_RDATA_RST;
    end else if (rd_fire) begin
      readdata_q <= rdata_d;
    end
  end

  assign avs_readdata = readdata_q;
  assign avs_waitrequest = waitreq_q;
  assign irq = irq_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_req;
    state_q == PSEC_BUS_IDLE && (avs_read || avs_write);
  endsequence
  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  AST_BUS_ANSWER:
  assert property (s_req |=> s_answer)
    else $error("bus answer not one cycle after request");
  AST_RF_SET:
  assert property (rf_set |=> rf_q ##1 quick_q.rem_fault)
    else $error("remote fault not latched");
  AST_RF_NO_AN:
  assert property (!rf_q && !phy_i.an_enable && !basic_rd |=> !rf_q)
    else $error("remote fault set without negotiation");
  AST_RF_CLR:
  assert property (basic_rd && !rf_set |=> !rf_q)
    else $error("basic read did not clear remote fault");
  AST_JAB_KEEP:
  assert property (quick_rd && jab_lat_q |=> jab_lat_q ##1 quick_q.jabber)
    else $error("quick read cleared jabber");
  AST_ANC:
  assert property ($past(rst_n) |-> quick_q.an_complete ==
    $past(phy_i.an_complete))
    else $error("negotiation complete bit wrong");
  AST_LPBK:
  assert property (phy_i.loopback |=> quick_q.loopback)
    else $error("loopback bit not set");
  AST_DUP_GATE:
  assert property (!stat_valid |=> !quick_q.full_dup &&
    !quick_q.low_speed_flag)
    else $error("duplex or speed shown without valid link");
  AST_DUP_FORCED:
  assert property (stat_valid && !phy_i.an_enable
    |=> quick_q.full_dup == $past(phy_i.frc_full_dup))
    else $error("forced duplex not shown");
  AST_LINK_KEEP:
  assert property (quick_rd && link_lat_q && phy_i.link_ok |=> link_lat_q)
    else $error("quick read changed link bit");
  AST_LINK_DOWN:
  assert property (!phy_i.link_ok |=> !link_lat_q ##1 !quick_q.link)
    else $error("link bit set without link");
  AST_RSVD_ZERO:
  assert property (rd_fire && !hit(idx, `PSEC_IDX_BASIC)
    |=> avs_readdata[31:8] == 24'h000000 && !(hit($past(idx),
    `PSEC_IDX_QUICK) && avs_readdata[7]))
    else $error("reserved bits not zero");
  AST_IRQ_LEVEL:
  assert property (|(istat_q & imask_q) |=> irq)
    else $error("interrupt not raised");
endmodule

// File: verification/psec_top_bench.sv
/*
  Self-checking bench for the PHY quick status and error counter bank.
  Assumes psec_top answers each Avalon-MM request two edges after it is
  raised and that line inputs are sampled on the same clock.
*/
`timescale 1ns/100ps
`include "psec_regs_regs.svh"
module psec_top_bench;
  import psec_pkg::*;
  // Clock and reset
  logic clk;
  logic rst_n;
  // Avalon-MM master side
  logic [7:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  // Line state and interrupt
  psec_phy_s phy_i;
  psec_rx_s rx_i;
  logic irq;
  int n_errors = 0;
  int n_tests = 0;
  logic [31:0] rd;

`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end

  ////////////////////////////////////////////////////////////////////////
  psec_top #(.CNT_W(8)) psec_top_i (
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .phy_i(phy_i), .rx_i(rx_i), .irq(irq)
  );

  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  // One bus cycle; optional false carrier pulse at the taking edge
  task automatic xfer(input bit wr, input logic [5:0] idx,
                      input logic [31:0] wd, input bit fc_at,
                      output logic [31:0] data);
    bit first;
    first = 1'b1;
    @(posedge clk);
    avs_address <= {idx, 2'b00};
    avs_read <= ~wr;
    avs_write <= wr;
    avs_writedata <= wd;
    avs_byteenable <= 4'hF;
    if (fc_at) rx_i.false_carrier <= 1'b1;
    // Hold the request until waitrequest is seen low at a rising edge;
    // a slave that never answers is left to the watchdog
    do begin
      @(posedge clk);
      if (fc_at && first) rx_i.false_carrier <= 1'b0;
      first = 1'b0;
    end while (avs_waitrequest !== 1'b0);
    // Read data is taken at the very edge that sees the answer
    data = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rdreg(input logic [5:0] idx);
    xfer(1'b0, idx, 32'h00000000, 1'b0, rd);
  endtask

  task automatic wrreg(input logic [5:0] idx, input logic [31:0] wd);
    logic [31:0] dummy;
    xfer(1'b1, idx, wd, 1'b0, dummy);
  endtask

  // Let registered outputs land, then look between edges
  task automatic settle;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic fc_pulses(input int n);
    repeat (n) begin
      @(posedge clk) rx_i.false_carrier <= 1'b1;
      @(posedge clk) rx_i.false_carrier <= 1'b0;
    end
  endtask

  // One carrier event with ninv invalid symbols inside it
  task automatic carrier_ev(input int ninv, input bit coll);
    @(posedge clk);
    rx_i.carrier <= 1'b1;
    rx_i.collision <= coll;
    repeat (ninv) begin
      @(posedge clk) rx_i.invalid_sym <= 1'b1;
      @(posedge clk) rx_i.invalid_sym <= 1'b0;
    end
    @(posedge clk);
    rx_i.carrier <= 1'b0;
    rx_i.collision <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // Expected quick status; duplex and speed held at 0 while not valid
  function automatic logic [7:0] qexp(psec_phy_s p, logic rf);
    logic v;
    v = p.link_ok & (~p.an_enable | p.an_complete);
    return {1'b0, rf, p.jabber, p.an_complete, p.loopback,
            v & (p.an_enable ? p.an_full_dup : p.frc_full_dup),
            v & (p.an_enable ? p.an_low_speed : p.frc_low_speed),
            p.link_ok};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset_vals;
    @(negedge clk);
    `CHK(avs_waitrequest, 1'b1) // bus idle after reset
    `CHK(irq, 1'b0) // no interrupt after reset
    rdreg(`PSEC_IDX_BASIC); `CHK(rd, 32'h00000000) // reset clears
    rdreg(`PSEC_IDX_FCAR); `CHK(rd, 32'h00000000) // reset zero
    rdreg(`PSEC_IDX_RXER); `CHK(rd, 32'h00000000) // reset zero
    rdreg(`PSEC_IDX_QUICK); `CHK(rd, 32'h00000000) // idle zero
    rdreg(6'h3F); `CHK(rd, 32'h00000000) // unmapped zero
  endtask

  // Every combination of negotiation, loopback, link and mode inputs
  task automatic t_quick_scan;
    psec_phy_s p;
    for (int i = 0; i < 256; i++) begin
      p = psec_phy_s'({2'b00, i[7:0]});
      @(posedge clk) phy_i <= p;
      settle();
      rdreg(`PSEC_IDX_QUICK);
      `CHK(rd, {24'h000000, qexp(p, 1'b0)})
    end
    // Jabber pulse latches; quick reads must leave it and link alone
    p = psec_phy_s'(10'h174);
    @(posedge clk) phy_i <= p;
    @(posedge clk) phy_i.jabber <= 1'b0;
    settle();
    repeat (2) begin
      rdreg(`PSEC_IDX_QUICK);
      `CHK(rd[7:0], qexp(p, 1'b0)) // no read clear
    end
    wrreg(`PSEC_IDX_QUICK, 32'hFFFFFFFF);
    rdreg(`PSEC_IDX_QUICK); `CHK(rd[7:0], qexp(p, 1'b0)) // read only
    rdreg(`PSEC_IDX_BASIC);
    `CHK(rd[`PSEC_BAS_JAB], 1'b1) // same latch as basic
    `CHK(rd[`PSEC_BAS_LINK], 1'b1) // mirrored link bit
    rdreg(`PSEC_IDX_QUICK); `CHK(rd[5], 1'b0) // basic read clears
  endtask

  task automatic t_rem_fault;
    @(posedge clk) phy_i <= psec_phy_s'(10'h204);
    settle();
    rdreg(`PSEC_IDX_QUICK); `CHK(rd[6], 1'b0) // needs negotiation
    @(posedge clk) phy_i.an_enable <= 1'b1;
    settle();
    @(posedge clk) phy_i.lp_rem_fault <= 1'b0;
    settle();
    rdreg(`PSEC_IDX_QUICK); `CHK(rd[6], 1'b1) // sticky set
    rdreg(`PSEC_IDX_QUICK); `CHK(rd[6], 1'b1) // quick read keeps
    rdreg(`PSEC_IDX_BASIC);
    rdreg(`PSEC_IDX_QUICK); `CHK(rd[6], 1'b0) // basic read clears
  endtask

  task automatic t_false_carrier;
    fc_pulses(5);
    rdreg(`PSEC_IDX_FCAR); `CHK(rd, 32'h00000005) // count
    rdreg(`PSEC_IDX_FCAR); `CHK(rd, 32'h00000000) // clear on read
    fc_pulses(300);
    rdreg(`PSEC_IDX_FCAR); `CHK(rd, 32'h000000FF) // sticks
    wrreg(`PSEC_IDX_FCAR, 32'hFFFFA537);
    rdreg(`PSEC_IDX_FCAR); `CHK(rd, 32'h00000037) // write
    fc_pulses(3);
    // Event lands on the very edge that takes the clearing read
    xfer(1'b0, `PSEC_IDX_FCAR, 32'h00000000, 1'b1, rd);
    `CHK(rd, 32'h00000003) // old value returned
    rdreg(`PSEC_IDX_FCAR); `CHK(rd, 32'h00000001) // event kept
  endtask

  task automatic t_rx_errors;
    carrier_ev(3, 1'b0);
    carrier_ev(0, 1'b0);
    carrier_ev(1, 1'b1);
    rdreg(`PSEC_IDX_RXER); `CHK(rd, 32'h00000001) // once
    repeat (260) carrier_ev(1, 1'b0);
    rdreg(`PSEC_IDX_RXER); `CHK(rd, 32'h000000FF) // sticks
    rdreg(`PSEC_IDX_RXER); `CHK(rd, 32'h00000000) // clear on read
    wrreg(`PSEC_IDX_RXER, 32'h0000FF42);
    rdreg(`PSEC_IDX_RXER); `CHK(rd, 32'h00000042) // write
  endtask

  task automatic t_irq;
    // Earlier scenarios raised every kind of event at least once
    rdreg(`PSEC_IDX_ISTAT); `CHK(rd, 32'h0000000F)
    wrreg(`PSEC_IDX_ISTAT, 32'h0000000F);
    wrreg(`PSEC_IDX_IMASK, 32'h00000001);
    rdreg(`PSEC_IDX_IMASK); `CHK(rd, 32'h00000001) // mask readback
    settle();
    `CHK(irq, 1'b0) // nothing pending
    fc_pulses(1);
    settle();
    `CHK(irq, 1'b1) // event raises
    rdreg(`PSEC_IDX_ISTAT); `CHK(rd[0], 1'b1) // status set
    wrreg(`PSEC_IDX_IMASK, 32'h00000000);
    settle();
    `CHK(irq, 1'b0) // masked
    wrreg(`PSEC_IDX_IMASK, 32'h00000001);
    wrreg(`PSEC_IDX_ISTAT, 32'h00000001);
    settle();
    `CHK(irq, 1'b0) // cleared by one
    rdreg(`PSEC_IDX_ISTAT); `CHK(rd[0], 1'b0) // write one clears
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    if (n_errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    rst_n = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'h0;
    phy_i = psec_phy_s'(10'h000);
    rx_i = psec_rx_s'(4'h0);
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset_vals();
    t_quick_scan();
    t_rem_fault();
    t_false_carrier();
    t_rx_errors();
    t_irq();
    summarize();
  end

  // Watchdog, well above the roughly 4500 cycles the tests need
  initial begin
    repeat (50000) @(posedge clk);
    n_errors++;
    summarize();
  end
endmodule
